// File: core/pfp_protect.sv
// What this block does
// - sense short judged only from first gate pulse width after start-up.
// - select high: first pulse capped at 2 us; cap hit starts recovery.
// - select low: cap 2 us if demag resistor above threshold, else 1 us.
// - sense above overcurrent for three straight pulses starts recovery.
// - bias regulator restores bias pin before any gate pulse.
// - 10 us after turn-on, bias below 14 V forces one lockout cycle.
// - bias above 15 V three straight pulses forces one lockout cycle.
// - timing pins tested for open and short before switching.
// - timing pin fault blocks switching, one lockout, retry next cycle.
// - every pin fault response recovers by itself; short means to ground.
`timescale 1ns/1ps
`default_nettype none
module pfp_protect
   import pfp_pkg::*;
#(
   parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYC
) (
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   // supply and straps
   input  wire logic       supply_on_i,
   input  wire logic       select_high_i,
   input  wire logic       demag_above_thr_i,
   // analog comparators
   input  wire logic       sense_over_i,
   input  wire logic       bias_below_14_i,
   input  wire logic       bias_over_15_i,
   input  wire pfp_rpin_t  rpin_i,
   // pwm request from the modulator
   input  wire logic       pulse_req_i,
   // controls
   output logic            bias_reg_en_o,
   output logic            rpin_test_en_o,
   output logic            low_side_gate_pulse_o,
   output logic            supply_lockout_cycle_o,
   output logic            fault_recovery_delay_o,
   output pfp_fault_t      fault_o
);
   pfp_state_t         state_ff;
   logic [CNT_W-1:0]   timer_ff;
   logic [1:0]         open_cnt_ff;
   logic [1:0]         ovp_cnt_ff;
   logic               gate_ff;
   logic               sense_hit_ff;
   logic               bias_hit_ff;
   pfp_fault_t         fault_ff;
   logic [CNT_W-1:0]   cap_cyc;
   logic               pulse_end;
   logic               cap_hit;
   logic               rpin_bad;
   logic               sense_seen;
   logic               bias_seen;
   logic               settle_done;
   logic               recover_done;
   logic               open_trip;
   logic               ovp_trip;

   function automatic logic [1:0] bump(input logic [1:0] c);
      return (c == 2'h3) ? c : c + 2'h1;
   endfunction

   // timer counts from zero, so a limit is met one edge early
   function automatic logic reached(input logic [CNT_W-1:0] t,
                                    input logic [CNT_W-1:0] lim);
      return (t + CNT_W'(1)) >= lim;
   endfunction

   always_comb begin
      if (select_high_i || demag_above_thr_i) begin
         cap_cyc = CNT_W'(CAP_WIDE_CYC);
      end else begin
         cap_cyc = CNT_W'(CAP_NARROW_CYC);
      end
   end

   assign pulse_end = gate_ff && !pulse_req_i;
   // width counted in cycles already driven; cap ends the pulse
   assign cap_hit = (state_ff == PFP_FIRST) && gate_ff &&
                    reached(timer_ff, cap_cyc);
   // a hit may fall on the very edge the pulse ends, so merge it in
   assign sense_seen   = sense_hit_ff | sense_over_i;
   assign bias_seen    = bias_hit_ff | bias_over_15_i;
   assign settle_done  = reached(timer_ff, CNT_W'(BIAS_CHK_CYC));
   assign recover_done = reached(timer_ff, CNT_W'(RECOVERY_CYCLES));
   assign open_trip    = pulse_end && sense_seen &&
                         (open_cnt_ff == 2'(CONSEC_LIMIT - 1));
   assign ovp_trip     = pulse_end && bias_seen &&
                         (ovp_cnt_ff == 2'(CONSEC_LIMIT - 1));
   // short means pin pulled to ground, current self-limited
   assign rpin_bad = |rpin_i;

   // gate drive
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         gate_ff <= 1'b0;
      end else if (state_ff == PFP_FIRST) begin
         gate_ff <= pulse_req_i && !cap_hit;
      end else if (state_ff == PFP_RUN) begin
         gate_ff <= pulse_req_i;
      end else begin
         gate_ff <= 1'b0;
      end
   end

   // per-pulse threshold memory
   // any hit during the on-time marks the whole pulse
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sense_hit_ff <= 1'b0;
         bias_hit_ff  <= 1'b0;
      end else if (!gate_ff) begin
         sense_hit_ff <= 1'b0;
         bias_hit_ff  <= 1'b0;
      end else begin
         sense_hit_ff <= sense_hit_ff | sense_over_i;
         bias_hit_ff  <= bias_hit_ff | bias_over_15_i;
      end
   end

   // consecutive pulse counters
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         open_cnt_ff <= CONSEC_RESET;
         ovp_cnt_ff  <= CONSEC_RESET;
      end else if (state_ff != PFP_RUN && state_ff != PFP_FIRST) begin
         open_cnt_ff <= CONSEC_RESET;
         ovp_cnt_ff  <= CONSEC_RESET;
      end else if (pulse_end) begin
         open_cnt_ff <= sense_seen ?
                        bump(open_cnt_ff) : CONSEC_RESET;
         ovp_cnt_ff  <= bias_seen ?
                        bump(ovp_cnt_ff) : CONSEC_RESET;
      end
   end

   // sequencing
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= PFP_IDLE;
         timer_ff <= '0;
         fault_ff <= '0;
      end else begin
         case (state_ff)
            PFP_IDLE: begin
               timer_ff <= '0;
               if (supply_on_i) begin
                  state_ff <= PFP_SETTLE;
                  fault_ff <= '0;
               end
            end
            PFP_SETTLE: begin
               timer_ff <= timer_ff + CNT_W'(1);
               if (settle_done) begin
                  timer_ff <= '0;
                  if (bias_below_14_i) begin
                     fault_ff.bias_open <= 1'b1;
                     state_ff <= PFP_LOCKOUT;
                  end else if (rpin_bad) begin
                     fault_ff.timing_pin <= 1'b1;
                     state_ff <= PFP_LOCKOUT;
                  end else begin
                     state_ff <= PFP_FIRST;
                  end
               end
            end
            PFP_FIRST: begin
               if (gate_ff) begin
                  timer_ff <= timer_ff + CNT_W'(1);
               end
               if (cap_hit) begin
                  fault_ff.sense_short <= 1'b1;
                  timer_ff <= '0;
                  state_ff <= PFP_RECOVER;
               end else if (pulse_end) begin
                  state_ff <= PFP_RUN;
               end
            end
            PFP_RUN: begin
               timer_ff <= '0;
               // open sense wins: it asks for the longer timed recovery
               if (open_trip) begin
                  fault_ff.sense_open <= 1'b1;
                  state_ff <= PFP_RECOVER;
               end else if (ovp_trip) begin
                  fault_ff.bias_over <= 1'b1;
                  state_ff <= PFP_LOCKOUT;
               end
            end
            PFP_RECOVER: begin
               timer_ff <= timer_ff + CNT_W'(1);
               // ends in lockout so the next supply cycle restarts clean
               if (recover_done) begin
                  timer_ff <= '0;
                  state_ff <= PFP_LOCKOUT;
               end
            end
            PFP_LOCKOUT: begin
               // only a fresh supply cycle leaves, so no fault latches
               timer_ff <= '0;
               if (!supply_on_i) begin
                  state_ff <= PFP_IDLE;
               end
            end
            default: begin
               state_ff <= PFP_IDLE;
            end
         endcase
      end
   end

   assign bias_reg_en_o          = (state_ff != PFP_IDLE);
   assign rpin_test_en_o         = (state_ff == PFP_SETTLE);
   assign low_side_gate_pulse_o  = gate_ff;
   assign supply_lockout_cycle_o = (state_ff == PFP_LOCKOUT);
   assign fault_recovery_delay_o = (state_ff == PFP_RECOVER);
   assign fault_o                = fault_ff;
endmodule // pfp_protect
`default_nettype wire

// File: core/pfp_pkg.sv
package pfp_pkg;
   localparam int unsigned CLK_MHZ = 40;
   // first pulse caps, in ns
   localparam int unsigned CAP_WIDE_NS = 2000;
   localparam int unsigned CAP_NARROW_NS = 1000;
   localparam int unsigned CAP_WIDE_CYC = (CAP_WIDE_NS * CLK_MHZ) / 1000;
   localparam int unsigned CAP_NARROW_CYC = (CAP_NARROW_NS * CLK_MHZ) / 1000;
   // bias sample delay after turn-on, in ns
   localparam int unsigned BIAS_CHK_NS = 10000;
   localparam int unsigned BIAS_CHK_CYC =
      (BIAS_CHK_NS * CLK_MHZ + 999) / 1000;
   // fault recovery delay, in ms
   localparam int unsigned RECOVERY_MS = 1500;
   localparam int unsigned RECOVERY_CYC = RECOVERY_MS * CLK_MHZ * 1000;
   localparam int unsigned CONSEC_LIMIT = 3;
   localparam int unsigned CNT_W = 32;
   localparam logic [1:0] CONSEC_RESET = 2'h0;

   typedef enum logic [2:0] {
      PFP_IDLE    = 3'b000,
      PFP_SETTLE  = 3'b001,
      PFP_FIRST   = 3'b010,
      PFP_RUN     = 3'b011,
      PFP_RECOVER = 3'b100,
      PFP_LOCKOUT = 3'b101
   } pfp_state_t;

   typedef struct packed {
      logic sense_short;
      logic sense_open;
      logic bias_open;
      logic bias_over;
      logic timing_pin;
   } pfp_fault_t;

   typedef struct packed {
      logic demag_open;
      logic demag_short;
      logic zvs_open;
      logic zvs_short;
   } pfp_rpin_t;
endpackage

// File: testbench/pfp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pfp_checker
   import pfp_pkg::*;
(
   input wire logic       sys_clk_i,
   input wire logic       reset_i,
   input wire logic       supply_on_i,
   input wire logic       pulse_req_i,
   input wire logic       bias_reg_en_o,
   input wire logic       rpin_test_en_o,
   input wire logic       low_side_gate_pulse_o,
   input wire logic       supply_lockout_cycle_o,
   input wire logic       fault_recovery_delay_o,
   input wire pfp_fault_t fault_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_lock; ##[0:1] supply_lockout_cycle_o; endsequence
   sequence s_rec; ##[0:1] fault_recovery_delay_o; endsequence
   property p_gate; low_side_gate_pulse_o |-> !(rpin_test_en_o |
      supply_lockout_cycle_o | fault_recovery_delay_o); endproperty
   property p_req; $rose(low_side_gate_pulse_o) |->
      $past(pulse_req_i) && $past(bias_reg_en_o); endproperty
   property p_short; $rose(fault_o.sense_short) |-> s_rec; endproperty
   property p_open; $rose(fault_o.sense_open) |-> s_rec; endproperty
   property p_bopen; $rose(fault_o.bias_open) |-> s_lock; endproperty
   property p_bover; $rose(fault_o.bias_over) |-> s_lock; endproperty
   property p_tpin; $rose(fault_o.timing_pin) |-> s_lock; endproperty
   property p_recend; $fell(fault_recovery_delay_o) |->
      supply_lockout_cycle_o; endproperty
   property p_hold; supply_lockout_cycle_o && supply_on_i |=>
      supply_lockout_cycle_o; endproperty
   a_gate: assert property (p_gate) else $error("gate out of window");
   a_req: assert property (p_req) else $error("gate without cause");
   a_short: assert property (p_short) else $error("no recovery");
   a_open: assert property (p_open) else $error("no recovery");
   a_bopen: assert property (p_bopen) else $error("no lockout");
   a_bover: assert property (p_bover) else $error("no lockout");
   a_tpin: assert property (p_tpin) else $error("no lockout");
   a_recend: assert property (p_recend) else $error("bad end");
   a_hold: assert property (p_hold) else $error("lockout lost");
endmodule // pfp_checker
bind pfp_protect pfp_checker u_chk (.sys_clk_i, .reset_i, .supply_on_i,
   .pulse_req_i, .bias_reg_en_o, .rpin_test_en_o, .low_side_gate_pulse_o,
   .supply_lockout_cycle_o, .fault_recovery_delay_o, .fault_o);
`default_nettype wire

// File: testbench/pfp_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module pfp_far_side
   import pfp_pkg::*;
(
   // controls from the block and fault picks {cs open, p13 low, p13 high}
   input  wire logic       gate_i,
   input  wire logic       bias_reg_en_i,
   input  wire logic       rpin_test_en_i,
   input  wire logic [2:0] flt_i,
   input  wire pfp_rpin_t  rpin_flt_i,
   // comparator outputs
   output logic            sense_over_o,
   output logic            bias_below_14_o,
   output logic            bias_over_15_o,
   output pfp_rpin_t       rpin_o
);
   // open pin is pulled up, so the level holds between pulses too
   assign sense_over_o = flt_i[2];
   // unregulated bias or untested pins give no trustworthy reading
   assign bias_below_14_o = bias_reg_en_i ? flt_i[1] : ~flt_i[1];
   assign bias_over_15_o = gate_i & flt_i[0];
   assign rpin_o = rpin_test_en_i ? rpin_flt_i : ~rpin_flt_i;
endmodule // pfp_far_side
`default_nettype wire

// File: testbench/tb_pin_fault_protection_logic.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pin_fault_protection_logic;
   import pfp_pkg::*;
   localparam int unsigned REC = 50;
   logic       sys_clk_i, reset_i, sup, sel, dem, req;
   logic       so, b14, b15, breg, rte, gate, lock, rec;
   logic [2:0] flt;
   pfp_rpin_t  rflt, rpin;
   pfp_fault_t fault;
   int         fails, n_compared;
   pfp_protect #(.RECOVERY_CYCLES(REC)) uut (.sys_clk_i, .reset_i,
      .supply_on_i(sup), .select_high_i(sel), .demag_above_thr_i(dem),
      .sense_over_i(so), .bias_below_14_i(b14), .bias_over_15_i(b15),
      .rpin_i(rpin), .pulse_req_i(req), .bias_reg_en_o(breg),
      .rpin_test_en_o(rte), .low_side_gate_pulse_o(gate),
      .supply_lockout_cycle_o(lock), .fault_recovery_delay_o(rec),
      .fault_o(fault));
   pfp_far_side far (.gate_i(gate), .bias_reg_en_i(breg),
      .rpin_test_en_i(rte), .flt_i(flt), .rpin_flt_i(rflt),
      .sense_over_o(so), .bias_below_14_o(b14), .bias_over_15_o(b15),
      .rpin_o(rpin));
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   task automatic give_verdict;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic start;
      sup <= 1'b0;
      tick(2);
      sup <= 1'b1;
      tick(404);
   endtask
   task automatic pulse(input int n);
      req <= 1'b1;
      tick(n);
      req <= 1'b0;
      tick(3);
   endtask
   task automatic t_short(input logic s, input logic d, input int cap);
      int n;
      n = 0;
      sel <= s;
      dem <= d;
      start;
      req <= 1'b1;
      repeat (200) begin
         @(negedge sys_clk_i);
         n += gate;
      end
      tick(1);
      req <= 1'b0;
      @(negedge sys_clk_i);
      chk(8'(n), 8'(cap));
      chk({fault, lock}, {5'h10, 1'b1});
      tick(1);
   endtask
   task automatic t_open;
      start;
      pulse(5);
      flt <= 3'b100;
      pulse(5);
      pulse(5);
      flt <= 3'b000;
      pulse(5);
      flt <= 3'b100;
      pulse(5);
      pulse(5);
      @(negedge sys_clk_i);
      chk(fault, 5'h00);
      tick(1);
      pulse(5);
      @(negedge sys_clk_i);
      chk({fault, rec}, {5'h08, 1'b1});
      // timed recovery must run out before the next start
      tick(REC);
      @(negedge sys_clk_i);
      chk({fault, rec, lock}, {5'h08, 2'b01});
      tick(1);
      flt <= 3'b000;
   endtask
   task automatic t_over;
      start;
      pulse(5);
      flt <= 3'b001;
      repeat (3) pulse(90);
      @(negedge sys_clk_i);
      chk({fault, lock}, {5'h02, 1'b1});
      tick(1);
      flt <= 3'b000;
   endtask
   task automatic t_start_faults;
      flt <= 3'b010;
      start;
      @(negedge sys_clk_i);
      chk({fault, lock, gate}, {5'h04, 2'b10});
      tick(1);
      flt <= 3'b000;
      for (int i = 0; i < 4; i++) begin
         rflt <= pfp_rpin_t'(4'h1 << i);
         start;
         @(negedge sys_clk_i);
         chk({fault, lock}, {5'h01, 1'b1});
         tick(1);
      end
      rflt <= '0;
      start;
      @(negedge sys_clk_i);
      chk({fault, lock, breg, rte}, {5'h00, 3'b010});
      tick(1);
   endtask
   initial begin
      {sup, sel, dem, req, flt, rflt, fails, n_compared} = '0;
      reset_i = 1'b1;
      tick(6);
      reset_i <= 1'b0;
      t_short(1'b1, 1'b0, CAP_WIDE_CYC);
      t_short(1'b0, 1'b1, CAP_WIDE_CYC);
      t_short(1'b0, 1'b0, CAP_NARROW_CYC);
      t_open;
      t_over;
      t_start_faults;
      give_verdict;
   end
   initial begin
      #500000;
      fails++;
      give_verdict;
   end
endmodule // tb_pin_fault_protection_logic
`default_nettype wire
